/* File: adc_mode_pkg.sv */
// Package of constants and types for the converter mode, alert and reset control.
package adc_mode_pkg;

  // Result widths.
  localparam int RESULT_W = 16;
  localparam int BOOST_W = 18;
  localparam int BOOST_SCLK_CYCLES = 18;
  localparam int STD_SCLK_CYCLES = 16;
  localparam int CHANNELS = 2;

  // Oversampling ratio field width and the rolling average depth.
  localparam int OSR_W = 3;
  localparam int FIFO_DEPTH = 8;

  // Reset field encodings of the secondary setup register.
  localparam logic [1:0] RESET_NONE = 2'h0;
  localparam logic [1:0] RESET_SOFT = 2'h1;
  localparam logic [1:0] RESET_HARD = 2'h2;

  // Power mode and reference source encodings.
  localparam logic POWER_MODE_BIT_NORMAL = 1'h0;
  localparam logic POWER_MODE_BIT_SHUTDOWN = 1'h1;
  localparam logic REF_INTERNAL = 1'h0;
  localparam logic REF_EXTERNAL = 1'h1;

  // Reset values of the primary and secondary setup fields.
  localparam logic RESET_BOOST = 1'h0;
  localparam logic RESET_OS_MODE = 1'h0;
  localparam logic [2:0] RESET_OSR = 3'h0;
  localparam logic RESET_ALERT_EN = 1'h0;
  localparam logic RESET_LANE_SEL = 1'h0;
  localparam logic [15:0] RESET_HIGH_LIMIT = 16'hFFFF;
  localparam logic [15:0] RESET_LOW_LIMIT = 16'h0000;

  // Conversion time on the internal oscillator, in ns, and its cycle count at 125 MHz.
  localparam int CLK_PERIOD_NS = 8;
  localparam int CONVERT_NS = 190;
  localparam int CONVERT_CYCLES = (CONVERT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Control sequencer states.
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_CONVERT = 4'h2,
    ST_SHUTDOWN = 4'h4,
    ST_RESET = 4'h8
  } ctrl_state_type;

endpackage : adc_mode_pkg

/* File: adc_sync2.sv */
// Two flip-flop synchroniser for a vector of inputs from outside the clock domain.
`timescale 1ns/1ps
module adc_sync2 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Asynchronous input and synchronised output.
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_q; // First stage, read only by the second stage.

  // Two stages; both reset to the idle level of the inputs, so no false edge follows reset.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      meta_q <= RESET_VAL;
      sync_o <= RESET_VAL;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule : adc_sync2

/* File: adc_avg_fifo.sv */
// Eight-entry rolling sample memory with a registered average output.
`timescale 1ns/1ps
module adc_avg_fifo
  import adc_mode_pkg::*;
#(
  parameter int WIDTH = RESULT_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Flush and sample input.
  input wire logic flush_i,
  input wire logic push_i,
  input wire logic [WIDTH-1:0] sample_i,
  // Averaging ratio as a power of two, 0 means no averaging.
  input wire logic [OSR_W-1:0] osr_i,
  // Registered average, two extra fraction bits below the integer.
  output logic [WIDTH+1:0] avg_o
);

  localparam int SUM_W = WIDTH + 3;

  // The ratio field reaches at most 2^3 samples.
  initial begin
    if (DEPTH != 8) begin
      $error("adc_avg_fifo needs a depth of 8");
    end
  end

  logic [WIDTH-1:0] mem_q [DEPTH]; // Sample memory, newest in slot 0.
  logic filled_q; // Cleared by a flush so the next sample fills every slot.
  logic [SUM_W-1:0] sum [DEPTH]; // Running sums of the newest samples.
  logic [SUM_W+1:0] scaled; // Sum scaled to integer plus two fraction bits.
  logic [OSR_W-1:0] shift_w; // Effective ratio, limited to three.

  // Running sums, one per prefix length.
  assign sum[0] = SUM_W'(mem_q[0]);
  genvar g;
  generate
    for (g = 1; g < DEPTH; g++) begin : g_sum
      assign sum[g] = sum[g-1] + SUM_W'(mem_q[g]);
    end
  endgenerate

  assign shift_w = (osr_i > 3'h3) ? 3'h3 : osr_i;
  assign scaled = ({2'h0, sum[(1 << shift_w) - 1]} << 2) >> shift_w;

  // Shift in each new sample; the first after a flush fills all slots.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || flush_i) begin
      filled_q <= 1'h0;
      avg_o <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else begin
      if (push_i) begin
        filled_q <= 1'h1;
        mem_q[0] <= sample_i;
        for (int i = 1; i < DEPTH; i++) begin
          mem_q[i] <= filled_q ? mem_q[i-1] : sample_i;
        end
      end
      avg_o <= scaled[WIDTH+1:0];
    end
  end

endmodule : adc_avg_fifo

/* File: adc_mode_ctrl.sv */
// Mode, alert and software reset control of a dual simultaneous-sampling converter.
// Function
// - Results are sixteen bits by default.
// - Boost plus oversampling gives eighteen-bit results.
// - Alert when result beyond upper or lower limit.
// - One pair of limits shared by both channels.
// - Two flag bits per channel, high and low.
// - Channel alerts ORed into one common alert.
// - Alert works with and without oversampling.
// - Alert pin and flags update at conversion end.
// - Frame select falling edge clears alert pin.
// - Software reset clears the flag bits.
// - Power mode bit: zero normal, one shutdown.
// - Normal: frame select edge starts conversion.
// - Shutdown powers analog down, interface stays.
// - Shutdown leaves configuration unchanged.
// - Reference bit: zero internal, one external.
// - Soft and hard reset by reset field.
// - Soft reset flushes state, keeps registers.
// - Hard reset also restores defaults, oscillator.
// - First conversion after reset fills averaging memory.
`timescale 1ns/1ps
module adc_mode_ctrl
  import adc_mode_pkg::*;
#(
  parameter int CONV_CYCLES = CONVERT_CYCLES
) (
  // Clock and synchronous active-low reset.
  input wire logic CLK_I,
  input wire logic RST_N_I,
  // Serial frame pins, asynchronous to CLK_I.
  input wire logic CS_N_I,
  input wire logic SCLK_I,
  // Configuration write strobe and fields from the serial decoder.
  input wire logic CFG_WE_I,
  input wire logic CFG_BOOST_I,
  input wire logic CFG_OS_MODE_I,
  input wire logic [OSR_W-1:0] CFG_OSR_I,
  input wire logic CFG_POWER_MODE_BIT_I,
  input wire logic CFG_REFERENCE_SOURCE_BIT_I,
  input wire logic CFG_ALERT_EN_I,
  input wire logic CFG_LANE_SEL_I,
  input wire logic [RESULT_W-1:0] CFG_HIGH_LIMIT_I,
  input wire logic [RESULT_W-1:0] CFG_LOW_LIMIT_I,
  // Reset field write strobe and value.
  input wire logic RESET_WE_I,
  input wire logic [1:0] RESET_FIELD_I,
  // Raw samples from the two converters.
  input wire logic [RESULT_W-1:0] SAMPLE_A_I,
  input wire logic [RESULT_W-1:0] SAMPLE_B_I,
  // Conversion results, left-justified in 18 bits, and their width.
  output logic [BOOST_W-1:0] RESULT_A_O,
  output logic [BOOST_W-1:0] RESULT_B_O,
  output logic RESULT_BOOST_O,
  output logic [5:0] RESULT_SCLK_O,
  output logic RESULT_VALID_O,
  // Alert flags: bit 0 A low, 1 A high, 2 B low, 3 B high.
  output logic [3:0] ALERT_FLAGS_O,
  output logic ALERT_PIN_N_O,
  output logic ALERT_OE_N_O,
  // Power and reference controls to the analog side.
  output logic ANALOG_PWR_O,
  output logic INT_REF_EN_O,
  output logic OSC_RESET_O,
  output logic CONVERTING_O,
  // Current configuration readback.
  output logic [7:0] CFG_STATE_O
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisation and frame select edge.

  initial begin
    if (CONV_CYCLES < 1) begin
      $error("adc_mode_ctrl needs a conversion count of at least one");
    end
    if (CONV_CYCLES > 256) begin
      $error("adc_mode_ctrl counts at most 256 conversion cycles");
    end
  end

  logic [1:0] pins_s; // Synchronised frame select and serial clock.
  logic cs_n_prev_q; // Previous synchronised frame select.
  logic cs_fall; // One-cycle pulse on a frame select falling edge.

  // Both pins reset to their idle levels, frame select high and link clock low,
  // so the edge detector sees no false frame start when reset is released.
  adc_sync2 #(.WIDTH(2), .RESET_VAL(2'h1)) u_sync (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .async_i({SCLK_I, CS_N_I}),
    .sync_o(pins_s)
  );

  // A frame start is a high-to-low step between two synchronised samples.
  assign cs_fall = cs_n_prev_q & ~pins_s[0];

  ////////////////////////////////////////////////////////////////////////////
  // Configuration register.

  logic boost_q, os_mode_q, power_mode_bit_q, reference_source_bit_q, alert_en_q, lane_sel_q; // Setup bits.
  logic [OSR_W-1:0] osr_q; // Oversampling ratio field.
  logic [RESULT_W-1:0] high_q, low_q; // Shared limits.
  logic soft_req, hard_req, any_reset; // Decoded reset requests.
  logic ref_toggle; // Reference source change, refills the averaging memory.

  assign soft_req = RESET_WE_I & (RESET_FIELD_I == RESET_SOFT);
  assign hard_req = RESET_WE_I & (RESET_FIELD_I == RESET_HARD);
  assign any_reset = soft_req | hard_req;
  assign ref_toggle = CFG_WE_I & (CFG_REFERENCE_SOURCE_BIT_I != reference_source_bit_q);

  // Configuration holds across power modes; only a hard reset or RST_N_I restores defaults.
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I || hard_req) begin
      boost_q <= RESET_BOOST;
      os_mode_q <= RESET_OS_MODE;
      osr_q <= RESET_OSR;
      power_mode_bit_q <= POWER_MODE_BIT_NORMAL;
      reference_source_bit_q <= REF_INTERNAL;
      alert_en_q <= RESET_ALERT_EN;
      lane_sel_q <= RESET_LANE_SEL;
      high_q <= RESET_HIGH_LIMIT;
      low_q <= RESET_LOW_LIMIT;
    end else if (CFG_WE_I) begin
      boost_q <= CFG_BOOST_I;
      os_mode_q <= CFG_OS_MODE_I;
      osr_q <= CFG_OSR_I;
      power_mode_bit_q <= CFG_POWER_MODE_BIT_I;
      reference_source_bit_q <= CFG_REFERENCE_SOURCE_BIT_I;
      alert_en_q <= CFG_ALERT_EN_I;
      lane_sel_q <= CFG_LANE_SEL_I;
      high_q <= CFG_HIGH_LIMIT_I;
      low_q <= CFG_LOW_LIMIT_I;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control sequencer.

  ctrl_state_type state_q, state_d; // Sequencer state.
  logic [7:0] conv_cnt_q; // Conversion time counter.
  logic conv_done; // Last conversion cycle.

  assign conv_done = (state_q == ST_CONVERT) && (conv_cnt_q == 8'(CONV_CYCLES - 1));

  // Next state: conversions start only in normal mode.
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (power_mode_bit_q == POWER_MODE_BIT_SHUTDOWN) begin
          state_d = ST_SHUTDOWN;
        end else if (cs_fall) begin
          state_d = ST_CONVERT;
        end
      end
      ST_CONVERT: begin
        if (conv_done) begin
          state_d = ST_IDLE;
        end
      end
      ST_SHUTDOWN: begin
        if (power_mode_bit_q == POWER_MODE_BIT_NORMAL) begin
          state_d = ST_IDLE;
        end
      end
      // The reset state lasts one cycle, long enough to drop any pending frame start.
      ST_RESET: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // State and counter; a software reset reinitialises the sequencer.
  // A soft or hard reset write also clears the counter, so an aborted conversion never completes.
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      state_q <= ST_IDLE;
      conv_cnt_q <= 8'h00;
      cs_n_prev_q <= 1'h1;
    end else begin
      cs_n_prev_q <= pins_s[0];
      state_q <= any_reset ? ST_RESET : state_d;
      conv_cnt_q <= (state_q == ST_CONVERT && !any_reset) ? conv_cnt_q + 8'h01 : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Averaging and result formatting.

  logic os_valid; // A valid oversampling mode is active.
  logic use_boost; // Eighteen-bit results.
  logic [BOOST_W-1:0] avg_a, avg_b; // Averaged results with two fraction bits.
  logic [BOOST_W-1:0] res_a, res_b; // Formatted results.
  logic flush; // Flush of the averaging memory.

  assign os_valid = os_mode_q & (osr_q != 3'h0);
  assign use_boost = boost_q & os_valid;
  assign flush = any_reset | ref_toggle;
  // Without boost the low two bits are zero, leaving a 16-bit word.
  assign res_a = use_boost ? avg_a : {avg_a[BOOST_W-1:2], 2'h0};
  assign res_b = use_boost ? avg_b : {avg_b[BOOST_W-1:2], 2'h0};

  adc_avg_fifo u_fifo_a (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .flush_i(flush),
    .push_i(conv_done),
    .sample_i(SAMPLE_A_I),
    .osr_i(os_valid ? osr_q : 3'h0),
    .avg_o(avg_a)
  );

  adc_avg_fifo u_fifo_b (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .flush_i(flush),
    .push_i(conv_done),
    .sample_i(SAMPLE_B_I),
    .osr_i(os_valid ? osr_q : 3'h0),
    .avg_o(avg_b)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Alert comparison, flags and pin.

  // The averaging memory registers its output, so its average of the new sample appears one edge
  // after the push; results and flags are taken one edge later still, never from the stale average.
  logic done_q; // The push into the averaging memory has happened.
  logic avg_ready_q; // The memory's average now includes the newest sample.
  logic [3:0] hit; // Strict limit violations per channel and side.
  logic alert_common; // OR of all channel alerts.

  // Compare the 16-bit result part, strictly, against the shared limits.
  assign hit[0] = res_a[BOOST_W-1:2] < low_q;
  assign hit[1] = res_a[BOOST_W-1:2] > high_q;
  assign hit[2] = res_b[BOOST_W-1:2] < low_q;
  assign hit[3] = res_b[BOOST_W-1:2] > high_q;
  assign alert_common = |hit;

  // Flags and pin update at conversion end; a frame select edge clears the pin.
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      done_q <= 1'h0;
      avg_ready_q <= 1'h0;
      ALERT_FLAGS_O <= 4'h0;
      ALERT_PIN_N_O <= 1'h1;
      ALERT_OE_N_O <= 1'h1;
      RESULT_A_O <= '0;
      RESULT_B_O <= '0;
      RESULT_VALID_O <= 1'h0;
    end else begin
      done_q <= conv_done & ~any_reset;
      avg_ready_q <= done_q & ~any_reset;
      ALERT_OE_N_O <= ~(lane_sel_q & alert_en_q);
      RESULT_VALID_O <= avg_ready_q;
      if (any_reset) begin
        ALERT_FLAGS_O <= 4'h0;
        ALERT_PIN_N_O <= 1'h1;
      end else if (avg_ready_q) begin
        ALERT_FLAGS_O <= hit;
        ALERT_PIN_N_O <= ~(alert_common & alert_en_q);
        RESULT_A_O <= res_a;
        RESULT_B_O <= res_b;
      end else if (cs_fall) begin
        ALERT_PIN_N_O <= 1'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power, reference and status outputs.

  // Registered analog controls and configuration readback.
  // Conversion status drops at once when a reset field write aborts the conversion.
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      ANALOG_PWR_O <= 1'h1;
      INT_REF_EN_O <= 1'h1;
      OSC_RESET_O <= 1'h0;
      CONVERTING_O <= 1'h0;
      RESULT_BOOST_O <= 1'h0;
      RESULT_SCLK_O <= 6'h10;
      CFG_STATE_O <= 8'h00;
    end else begin
      ANALOG_PWR_O <= (power_mode_bit_q == POWER_MODE_BIT_NORMAL);
      INT_REF_EN_O <= (power_mode_bit_q == POWER_MODE_BIT_NORMAL) && (reference_source_bit_q == REF_INTERNAL);
      OSC_RESET_O <= hard_req;
      CONVERTING_O <= (state_d == ST_CONVERT) && !any_reset;
      RESULT_BOOST_O <= use_boost;
      RESULT_SCLK_O <= use_boost ? 6'(BOOST_SCLK_CYCLES) : 6'(STD_SCLK_CYCLES);
      CFG_STATE_O <= {lane_sel_q, alert_en_q, reference_source_bit_q, power_mode_bit_q, osr_q[1:0], os_mode_q, boost_q};
    end
  end

endmodule : adc_mode_ctrl

/* File: adc_host_model.sv */
// Behavioural serial host that frames transfers with frame select and the link clock.
`timescale 1ns/1ps
module adc_host_model (
  // Frame select and link clock towards the device.
  output logic cs_n_o,
  output logic sclk_o
);
  ////////////////////////////////////////////////////////////
  // Both lines start idle, and the link clock stands still between frames.
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
  end

  // One frame: select, n link clock cycles of 125 ns, then deselect.
  task automatic frame(input int n);
    cs_n_o = 1'b0;
    repeat (n) begin
      #62.5 sclk_o = 1'b1;
      #62.5 sclk_o = 1'b0;
    end
    #62.5 cs_n_o = 1'b1;
  endtask : frame
endmodule : adc_host_model

/* File: adc_mode_ctrl_sva.sv */
// Concurrent checks of the converter mode, alert and software reset control.
`timescale 1ns/1ps
module adc_mode_ctrl_sva
  import adc_mode_pkg::*;
#(
  parameter int CONV_CYCLES = 24
) (
  // Clock, reset and frame select.
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic CS_N_I,
  // Reset field and limits.
  input wire logic RESET_WE_I,
  input wire logic [1:0] RESET_FIELD_I,
  input wire logic [RESULT_W-1:0] CFG_HIGH_LIMIT_I,
  input wire logic [RESULT_W-1:0] CFG_LOW_LIMIT_I,
  // Observed outputs.
  input wire logic [BOOST_W-1:0] RESULT_A_O,
  input wire logic [BOOST_W-1:0] RESULT_B_O,
  input wire logic RESULT_BOOST_O,
  input wire logic [5:0] RESULT_SCLK_O,
  input wire logic RESULT_VALID_O,
  input wire logic [3:0] ALERT_FLAGS_O,
  input wire logic ALERT_PIN_N_O,
  input wire logic ALERT_OE_N_O,
  input wire logic ANALOG_PWR_O,
  input wire logic INT_REF_EN_O,
  input wire logic OSC_RESET_O,
  input wire logic CONVERTING_O,
  input wire logic [7:0] CFG_STATE_O
);
  ////////////////////////////////////////////////////////////
  // Result window after a conversion starts.
  localparam int VMIN = CONV_CYCLES;
  localparam int VMAX = CONV_CYCLES + 3;

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);

  // Named steps of the frame and reset behaviour.
  sequence cs_fall; $fell(CS_N_I); endsequence
  sequence soft_wr; RESET_WE_I && RESET_FIELD_I == RESET_SOFT; endsequence
  sequence hard_wr; RESET_WE_I && RESET_FIELD_I == RESET_HARD; endsequence
  sequence plain_done; RESULT_VALID_O && !RESULT_BOOST_O; endsequence

  ////////////////////////////////////////////////////////////
  AST_START: assert property (cs_fall ##0 (!CONVERTING_O && !CFG_STATE_O[4]) |-> ##[2:5] CONVERTING_O)
    else $error("frame start did not begin a conversion");
  AST_SHUT_IGNORE: assert property (cs_fall ##0 CFG_STATE_O[4] |-> !CONVERTING_O [*6])
    else $error("conversion started in shutdown");
  AST_CONV_LEN: assert property ($rose(CONVERTING_O) |-> ##[VMIN:VMAX] RESULT_VALID_O)
    else $error("result not delivered at conversion end");
  AST_PIN_CLR: assert property (cs_fall |-> ##[1:5] ALERT_PIN_N_O)
    else $error("alert pin not cleared by frame start");
  AST_A_LIM: assert property (plain_done |-> ALERT_FLAGS_O[1:0] == {RESULT_A_O[17:2] > CFG_HIGH_LIMIT_I,
    RESULT_A_O[17:2] < CFG_LOW_LIMIT_I}) else $error("channel A flags wrong");
  AST_B_LIM: assert property (plain_done |-> ALERT_FLAGS_O[3:2] == {RESULT_B_O[17:2] > CFG_HIGH_LIMIT_I,
    RESULT_B_O[17:2] < CFG_LOW_LIMIT_I}) else $error("channel B flags wrong");
  AST_OR: assert property (RESULT_VALID_O && CFG_STATE_O[6] |-> ALERT_PIN_N_O == !(|ALERT_FLAGS_O))
    else $error("alert pin is not the OR of flags");
  AST_WIDTH: assert property (RESULT_VALID_O |-> RESULT_SCLK_O == (RESULT_BOOST_O ? 6'h12 : 6'h10))
    else $error("result clock count wrong");
  AST_BOOST: assert property (RESULT_VALID_O && RESULT_BOOST_O |-> CFG_STATE_O[1:0] == 2'h3)
    else $error("boost without oversampling");
  AST_HOLD: assert property ($changed(ALERT_FLAGS_O) |-> RESULT_VALID_O || $past(RESET_WE_I)
    || $past(RESET_WE_I, 2) || $past(RESET_WE_I, 3)) else $error("flags changed off conversion end");
  AST_SOFT: assert property (soft_wr |-> ##[1:3] ALERT_FLAGS_O == 4'h0)
    else $error("soft reset left flags set");
  AST_SOFT_KEEP: assert property (soft_wr |=> $stable(CFG_STATE_O) [*3])
    else $error("soft reset changed setup");
  AST_HARD: assert property (hard_wr |-> ##[1:3] (CFG_STATE_O == 8'h00 && ALERT_FLAGS_O == 4'h0))
    else $error("hard reset left setup or flags");
  AST_OSC: assert property (hard_wr |-> ##[0:3] OSC_RESET_O)
    else $error("oscillator reset missing");
  AST_PWR: assert property ($stable(CFG_STATE_O[4]) |-> ANALOG_PWR_O == !CFG_STATE_O[4])
    else $error("analog power does not follow power mode");
  AST_REF: assert property ($stable(CFG_STATE_O[5:4]) |-> INT_REF_EN_O == (CFG_STATE_O[5:4] == 2'h0))
    else $error("reference enable wrong");
  AST_OE: assert property ($stable(CFG_STATE_O[7:6]) |-> ALERT_OE_N_O == !(&CFG_STATE_O[7:6]))
    else $error("alert pin enable wrong");
endmodule : adc_mode_ctrl_sva

bind adc_mode_ctrl adc_mode_ctrl_sva #(.CONV_CYCLES(CONV_CYCLES)) i_adc_mode_ctrl_sva (
  .CLK_I(CLK_I), .RST_N_I(RST_N_I), .CS_N_I(CS_N_I), .RESET_WE_I(RESET_WE_I), .RESET_FIELD_I(RESET_FIELD_I),
  .CFG_HIGH_LIMIT_I(CFG_HIGH_LIMIT_I), .CFG_LOW_LIMIT_I(CFG_LOW_LIMIT_I), .RESULT_A_O(RESULT_A_O),
  .RESULT_B_O(RESULT_B_O), .RESULT_BOOST_O(RESULT_BOOST_O), .RESULT_SCLK_O(RESULT_SCLK_O),
  .RESULT_VALID_O(RESULT_VALID_O), .ALERT_FLAGS_O(ALERT_FLAGS_O), .ALERT_PIN_N_O(ALERT_PIN_N_O),
  .ALERT_OE_N_O(ALERT_OE_N_O), .ANALOG_PWR_O(ANALOG_PWR_O), .INT_REF_EN_O(INT_REF_EN_O),
  .OSC_RESET_O(OSC_RESET_O), .CONVERTING_O(CONVERTING_O), .CFG_STATE_O(CFG_STATE_O));

/* File: adc_mode_ctrl_tb_top.sv */
// Self-checking testbench of the converter mode, alert and software reset control.
`timescale 1ns/1ps
module adc_mode_ctrl_tb_top;
  import adc_mode_pkg::*;
  localparam int CONV = 4; // Shortened conversion so frames stay brief.
  // Upper limit, kept above the lower one.
  localparam logic [15:0] HI = 16'h8000;
  localparam logic [15:0] LO = 16'h1000;
  logic clk = 1'b0, rst_n = 1'b0, cs_n, sclk, cfg_we = 1'b0, boost = 1'b0, os_mode = 1'b0;
  logic power_mode_bit = 1'b0, reference_source_bit = 1'b0, alert_en = 1'b0, lane_sel = 1'b0, reset_we = 1'b0;
  logic [2:0] osr = 3'h0;
  logic [1:0] reset_field = 2'h0;
  logic [15:0] sample_a = 16'h0000, sample_b = 16'h0000;
  logic [17:0] res_a, res_b;
  logic res_boost, res_valid, pin_n, oe_n, pwr, ref_en, osc_rst, converting;
  logic [5:0] res_sclk;
  logic [3:0] flags;
  logic [7:0] cfg_state;
  int failures = 0, check_count = 0;
  logic [31:0] seed = 32'h0000_0044; // Random source state.
  logic [37:0] exp_q[$]; // Expected {pin, boost, flags, b, a} per conversion.
  logic [37:0] e;

  always #4 clk = ~clk;

  adc_host_model i_adc_host_model (.cs_n_o(cs_n), .sclk_o(sclk));
  adc_mode_ctrl #(.CONV_CYCLES(CONV)) i_adc_mode_ctrl (.CLK_I(clk), .RST_N_I(rst_n), .CS_N_I(cs_n), .SCLK_I(sclk),
    .CFG_WE_I(cfg_we), .CFG_BOOST_I(boost), .CFG_OS_MODE_I(os_mode), .CFG_OSR_I(osr), .CFG_POWER_MODE_BIT_I(power_mode_bit),
    .CFG_REFERENCE_SOURCE_BIT_I(reference_source_bit), .CFG_ALERT_EN_I(alert_en), .CFG_LANE_SEL_I(lane_sel), .CFG_HIGH_LIMIT_I(HI),
    .CFG_LOW_LIMIT_I(LO), .RESET_WE_I(reset_we), .RESET_FIELD_I(reset_field), .SAMPLE_A_I(sample_a),
    .SAMPLE_B_I(sample_b), .RESULT_A_O(res_a), .RESULT_B_O(res_b), .RESULT_BOOST_O(res_boost),
    .RESULT_SCLK_O(res_sclk), .RESULT_VALID_O(res_valid), .ALERT_FLAGS_O(flags), .ALERT_PIN_N_O(pin_n),
    .ALERT_OE_N_O(oe_n), .ANALOG_PWR_O(pwr), .INT_REF_EN_O(ref_en), .OSC_RESET_O(osc_rst),
    .CONVERTING_O(converting), .CFG_STATE_O(cfg_state));

  ////////////////////////////////////////////////////////////
  // Compares a seen value with an expected one and counts both outcomes.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // Xorshift source for random samples.
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // Waits n rising edges, then steps off the edge.
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  // Loads the setup fields {lane, alert, ref, power, osr, os, boost} and reads them back.
  task automatic cfg(input logic [7:0] v);
    {lane_sel, alert_en, reference_source_bit, power_mode_bit, osr[1:0], os_mode, boost} = v;
    cfg_we = 1'b1;
    step(1);
    cfg_we = 1'b0;
    step(2);
    chk(cfg_state, v);
  endtask : cfg

  // Writes the reset field; the flags must be clear afterwards.
  task automatic swrst(input logic [1:0] f);
    reset_field = f;
    reset_we = 1'b1;
    step(1);
    chk(osc_rst, f == RESET_HARD);
    reset_we = 1'b0;
    step(3);
    chk(flags, 4'h0);
  endtask : swrst

  // Runs one frame of n link clocks and notes the expected result.
  task automatic conv(input logic [15:0] a, input logic [15:0] b, input int n);
    logic [3:0] f;
    f = {b > HI, b < LO, a > HI, a < LO};
    sample_a = a;
    sample_b = b;
    exp_q.push_back({~(alert_en && (|f)), boost && os_mode && (osr != 3'h0), f, b, a});
    fork
      i_adc_host_model.frame(n);
      begin
        step(5);
        chk(pin_n, 1'b1);
        chk(converting, 1'b1);
      end
    join
    step(4);
    chk(exp_q.size(), 0);
  endtask : conv

  // Prints the counts and the verdict, then ends the run.
  task automatic end_sim();
    $display("checks=%0d failures=%0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_sim

  ////////////////////////////////////////////////////////////
  // Takes the oldest note whenever a result appears and compares it.
  always @(negedge clk) begin
    if (res_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk(32'h0, 32'h1);
      end else begin
        e = exp_q.pop_front();
        chk(flags, e[35:32]);
        chk(pin_n, e[37]);
        chk(res_boost, e[36]);
        chk(res_sclk, e[36] ? 32'h12 : 32'h10);
        chk(res_a, {e[15:0], 2'h0});
        chk(res_b, {e[31:16], 2'h0});
      end
    end
  end

  // Main sequence of scenarios.
  initial begin
    logic [31:0] r;
    repeat (6) @(posedge clk);
    #1;
    rst_n = 1'b1;
    step(1);
    chk({flags, pin_n, oe_n, pwr, ref_en, cfg_state}, {8'h0F, 8'h00});
    chk(res_sclk, 32'h10);
    cfg(8'hC0);
    chk(oe_n, 1'b0);
    repeat (6) begin
      r = rnd();
      conv(r[15:0], r[31:16], 16);
    end
    conv(16'h8000, 16'h1000, 16);
    conv(16'h0FFF, 16'h8001, 16);
    conv(16'h8001, 16'h0FFF, 16);
    conv(16'h1001, 16'h7FFF, 16);
    conv(16'h0000, 16'hFFFF, 16);
    cfg(8'hC7);
    swrst(RESET_SOFT);
    chk(cfg_state, 8'hC7);
    conv(16'h1234, 16'hF00D, 18);
    cfg(8'hC6);
    swrst(RESET_SOFT);
    conv(16'h0800, 16'h9000, 16);
    cfg(8'hE0);
    chk(ref_en, 1'b0);
    cfg(8'hD0);
    chk({pwr, ref_en}, 2'h0);
    fork
      i_adc_host_model.frame(16);
      begin
        step(5);
        chk(converting, 1'b0);
      end
    join
    step(8);
    cfg(8'hC0);
    chk(pwr, 1'b1);
    step(20);
    conv(16'h4000, 16'h4000, 16);
    cfg(8'h40);
    chk(oe_n, 1'b1);
    swrst(RESET_HARD);
    chk(cfg_state, 8'h00);
    end_sim();
  end

  // Cuts a hang short well beyond the expected run time.
  initial begin
    #300000;
    failures++;
    end_sim();
  end
endmodule : adc_mode_ctrl_tb_top
